// *** src/ssta_pkg.sv ***
// Constants and types shared by the subtract, swap and test-mask execution unit
package ssta_pkg;

   // ==========================================================
   // Register map (byte addresses on the AXI4-Lite bus)
   localparam logic [7:0] ADDR_CMD    = 8'h00;
   localparam logic [7:0] ADDR_DST    = 8'h04;
   localparam logic [7:0] ADDR_SRC    = 8'h08;
   localparam logic [7:0] ADDR_FLAGS  = 8'h0c;
   localparam logic [7:0] ADDR_OPND   = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_RESULT = 8'h18;
   localparam logic [7:0] ADDR_DECODE = 8'h1c;

   // ==========================================================
   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Flag byte layout and reset value
   localparam int         FLAG_C      = 7;
   localparam int         FLAG_Z      = 6;
   localparam int         FLAG_S      = 5;
   localparam int         FLAG_V      = 4;
   localparam int         FLAG_D      = 3;
   localparam int         FLAG_H      = 2;
   localparam logic [7:0] FLAG_MASK   = 8'hfc;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   // ==========================================================
   // Status word bit positions
   localparam int STAT_BUSY    = 0;
   localparam int STAT_DONE    = 1;
   localparam int STAT_ILLEGAL = 2;
   localparam int STAT_DSTWR   = 3;
   localparam int STAT_SRCWR   = 4;

   // ==========================================================
   // Decode word bit positions
   localparam int DEC_DST_WORK = 0;
   localparam int DEC_DST_IDX  = 1;
   localparam int DEC_SRC_WORK = 5;
   localparam int DEC_SRC_IDX  = 6;
   localparam int DEC_DST_IND  = 10;
   localparam int DEC_SRC_IND  = 11;
   localparam int DEC_SRC_IMM  = 12;
   localparam int DEC_CYCLES   = 16;

   // ==========================================================
   // Opcodes, operand encoding and execution lengths
   localparam logic [3:0] OPC_SBC_HI      = 4'h3;
   localparam logic [3:0] OPC_TCM_HI      = 4'h6;
   localparam logic [7:0] OPC_SWAP_R      = 8'hf0;
   localparam logic [7:0] OPC_SWAP_IR     = 8'hf1;
   localparam logic [3:0] FORM_FIRST      = 4'h2;
   localparam logic [3:0] FORM_SHORT_LAST = 4'h3;
   localparam logic [3:0] FORM_REG_IND    = 4'h5;
   localparam logic [3:0] FORM_IMM        = 4'h6;
   localparam logic [3:0] FORM_IND_IMM    = 4'h7;
   localparam logic [3:0] FORM_LAST       = 4'h7;
   localparam logic [3:0] WORK_HI         = 4'he;
   localparam logic [3:0] CYC_SHORT       = 4'h6;
   localparam logic [3:0] CYC_LONG        = 4'ha;
   localparam logic [3:0] CYC_ILLEGAL     = 4'h1;

   // ==========================================================
   // Types
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01,
      ST_DONE = 2'b11
   } ssta_state_t;

   typedef enum logic [1:0]
   {
      no_op                   = 2'h0,
      subtract_with_borrow_op = 2'h1,
      nibble_swap_op          = 2'h2,
      test_ones_under_mask_op = 2'h3
   } ssta_op_t;

endpackage : ssta_pkg

// *** src/ssta_alu.sv ***
// Execution unit for subtract with borrow, nibble swap and test-ones-under-mask, AXI4-Lite slave
//
// Overview of operation
// - Subtract with borrow writes destination minus source minus carry to destination.
// - Subtraction adds the inverted source plus inverted carry to the destination.
// - Subtract with borrow never writes the source location.
// - Carry flag set on borrow, cleared on carry out of bit 7.
// - Zero flag set exactly when the subtraction result is zero.
// - Overflow set when operand signs differ and result sign equals source sign.
// - Sign flag copies bit 7 of the subtraction result.
// - Half-carry set on borrow, cleared on carry out of bit 3.
// - Subtract with borrow always sets the decimal-adjust flag.
// - Subtract opcodes 32 to 37; short forms 6 cycles, others 10.
// - In register modes, operand byte with high nibble 1110b selects a working register.
// - Nibble swap exchanges the two nibbles and writes them back.
// - Swap updates zero and sign; carry, decimal-adjust, half-carry kept.
// - Swap uses opcodes F0 and F1, six cycles each.
// - Mask test ANDs the inverted destination with the mask, flags only.
// - Mask test sets zero when all masked destination bits are one.
// - Mask test writes neither destination nor source.
// - Mask test copies result bit 7 to sign, clears overflow, keeps D and H.
// - Mask test opcodes 62 to 67, same forms and lengths as subtraction.
`timescale 1ns/1ps
module ssta_alu (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready
);

   // ==========================================================
   // Decoding helpers
   function automatic ssta_pkg::ssta_op_t opKind(input logic [7:0] opc);
      logic legal;
      legal = (opc[3:0] >= ssta_pkg::FORM_FIRST) && (opc[3:0] <= ssta_pkg::FORM_LAST);
      if (opc == ssta_pkg::OPC_SWAP_R || opc == ssta_pkg::OPC_SWAP_IR)
         return ssta_pkg::nibble_swap_op;
      if (legal && opc[7:4] == ssta_pkg::OPC_SBC_HI)
         return ssta_pkg::subtract_with_borrow_op;
      if (legal && opc[7:4] == ssta_pkg::OPC_TCM_HI)
         return ssta_pkg::test_ones_under_mask_op;
      return ssta_pkg::no_op;
   endfunction : opKind

   function automatic logic [3:0] opCycles(input logic [7:0] opc);
      ssta_pkg::ssta_op_t k;
      k = opKind(opc);
      if (k == ssta_pkg::no_op)
         return ssta_pkg::CYC_ILLEGAL;
      if (k == ssta_pkg::nibble_swap_op || opc[3:0] <= ssta_pkg::FORM_SHORT_LAST)
         return ssta_pkg::CYC_SHORT;
      return ssta_pkg::CYC_LONG;
   endfunction : opCycles

   function automatic logic isWork(input logic [7:0] b);
      return b[7:4] == ssta_pkg::WORK_HI;
   endfunction : isWork

   function automatic logic isMapped(input logic [7:0] a);
      return a[7:5] == 3'h0 && a[1:0] == 2'h0;
   endfunction : isMapped

   // ==========================================================
   // State
   ssta_pkg::ssta_state_t state_q;
   ssta_pkg::ssta_op_t    op;
   logic [3:0]            cnt_q;
   logic [7:0]            opcode_q;
   logic [7:0]            dstVal_q;
   logic [7:0]            srcVal_q;
   logic [15:0]           opnd_q;
   logic [7:0]            flags_q;
   logic [7:0]            result_q;
   logic                  dstWr_q;
   logic                  srcWr_q;
   logic                  done_q;
   logic                  illegal_q;
   logic                  haveAw_q;
   logic                  haveW_q;
   logic [7:0]            awAddr_q;
   logic [31:0]           wData_q;
   logic [3:0]            wStrb_q;
   logic                  wrCommit;
   logic                  idle;
   logic                  startCmd;
   logic [3:0]            form;
   logic [7:0]            srcEff;
   logic                  cIn;
   logic [8:0]            sbcSum;
   logic [4:0]            sbcLow;
   logic [7:0]            resNext;
   logic [7:0]            flagsNext;
   logic                  dstWrNext;
   logic [31:0]           decodeWord;
   logic [31:0]           rdNext;

   assign op       = opKind(opcode_q);
   assign form     = opcode_q[3:0];
   assign idle     = state_q == ssta_pkg::ST_IDLE;
   assign wrCommit = haveAw_q && haveW_q && !bvalid;
   assign startCmd = wrCommit && idle && wStrb_q[0] && awAddr_q[7:2] == ssta_pkg::ADDR_CMD[7:2];

   // ==========================================================
   // AXI4-Lite write channels
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         awready  <= 1'b1;
         wready   <= 1'b1;
         haveAw_q <= 1'b0;
         haveW_q  <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q  <= 32'h0000_0000;
         wStrb_q  <= 4'h0;
         bvalid   <= 1'b0;
         bresp    <= ssta_pkg::RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            awready  <= 1'b0;
            haveAw_q <= 1'b1;
            awAddr_q <= awaddr;
         end
         if (wvalid && wready)
         begin
            wready  <= 1'b0;
            haveW_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
         end
         if (wrCommit)
         begin
            haveAw_q <= 1'b0;
            haveW_q  <= 1'b0;
            bvalid   <= 1'b1;
            bresp    <= isMapped(awAddr_q) ? ssta_pkg::RESP_OKAY : ssta_pkg::RESP_SLVERR;
         end
         if (bvalid && bready)
         begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Software-written operand registers, only while idle
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         opcode_q <= 8'h00;
         dstVal_q <= 8'h00;
         srcVal_q <= 8'h00;
         opnd_q   <= 16'h0000;
      end
      else if (wrCommit && idle)
      begin
         if (startCmd)
            opcode_q <= wData_q[7:0];
         if (awAddr_q[7:2] == ssta_pkg::ADDR_DST[7:2] && wStrb_q[0])
            dstVal_q <= wData_q[7:0];
         if (awAddr_q[7:2] == ssta_pkg::ADDR_SRC[7:2] && wStrb_q[0])
            srcVal_q <= wData_q[7:0];
         if (awAddr_q[7:2] == ssta_pkg::ADDR_OPND[7:2] && wStrb_q[0])
            opnd_q[7:0] <= wData_q[7:0];
         if (awAddr_q[7:2] == ssta_pkg::ADDR_OPND[7:2] && wStrb_q[1])
            opnd_q[15:8] <= wData_q[15:8];
      end
   end

   // ==========================================================
   // Execution sequencer
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_q <= ssta_pkg::ST_IDLE;
         cnt_q   <= 4'h0;
      end
      else
      begin
         case (state_q)
            ssta_pkg::ST_IDLE:
            begin
               if (startCmd && opKind(wData_q[7:0]) == ssta_pkg::no_op)
                  state_q <= ssta_pkg::ST_DONE;
               else if (startCmd)
               begin
                  state_q <= ssta_pkg::ST_RUN;
                  cnt_q   <= opCycles(wData_q[7:0]) - 4'h1;
               end
            end
            ssta_pkg::ST_RUN:
            begin
               cnt_q <= cnt_q - 4'h1;
               if (cnt_q == 4'h1)
                  state_q <= ssta_pkg::ST_DONE;
            end
            ssta_pkg::ST_DONE:
               state_q <= ssta_pkg::ST_IDLE;
            default:
               state_q <= ssta_pkg::ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Datapath and flag evaluation
   assign srcEff = (op != ssta_pkg::nibble_swap_op && form >= ssta_pkg::FORM_IMM) ? opnd_q[15:8] : srcVal_q;
   assign cIn    = flags_q[ssta_pkg::FLAG_C];
   assign sbcSum = {1'b0, dstVal_q} + {1'b0, ~srcEff} + {8'h00, ~cIn};
   assign sbcLow = {1'b0, dstVal_q[3:0]} + {1'b0, ~srcEff[3:0]} + {4'h0, ~cIn};

   always_comb
   begin
      resNext   = dstVal_q;
      flagsNext = flags_q;
      dstWrNext = 1'b0;
      case (op)
         ssta_pkg::subtract_with_borrow_op:
         begin
            resNext                   = sbcSum[7:0];
            dstWrNext                 = 1'b1;
            flagsNext[ssta_pkg::FLAG_C] = ~sbcSum[8];
            flagsNext[ssta_pkg::FLAG_Z] = sbcSum[7:0] == 8'h00;
            flagsNext[ssta_pkg::FLAG_V] = (dstVal_q[7] != srcEff[7]) && (sbcSum[7] == srcEff[7]);
            flagsNext[ssta_pkg::FLAG_S] = sbcSum[7];
            flagsNext[ssta_pkg::FLAG_H] = ~sbcLow[4];
            flagsNext[ssta_pkg::FLAG_D] = 1'b1;
         end
         ssta_pkg::nibble_swap_op:
         begin
            resNext                   = {dstVal_q[3:0], dstVal_q[7:4]};
            dstWrNext                 = 1'b1;
            flagsNext[ssta_pkg::FLAG_Z] = dstVal_q == 8'h00;
            flagsNext[ssta_pkg::FLAG_S] = dstVal_q[3];
         end
         ssta_pkg::test_ones_under_mask_op:
         begin
            resNext                   = ~dstVal_q & srcEff;
            flagsNext[ssta_pkg::FLAG_Z] = (~dstVal_q & srcEff) == 8'h00;
            flagsNext[ssta_pkg::FLAG_S] = ~dstVal_q[7] & srcEff[7];
            flagsNext[ssta_pkg::FLAG_V] = 1'b0;
         end
         default:
            resNext = dstVal_q;
      endcase
   end

   // ==========================================================
   // Result, flags and status
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         flags_q   <= ssta_pkg::FLAGS_RESET;
         result_q  <= 8'h00;
         dstWr_q   <= 1'b0;
         srcWr_q   <= 1'b0;
         illegal_q <= 1'b0;
      end
      else if (state_q == ssta_pkg::ST_DONE)
      begin
         flags_q   <= flagsNext;
         result_q  <= resNext;
         dstWr_q   <= dstWrNext;
         srcWr_q   <= 1'b0;
         illegal_q <= op == ssta_pkg::no_op;
      end
      else if (wrCommit && idle && wStrb_q[0] && awAddr_q[7:2] == ssta_pkg::ADDR_FLAGS[7:2])
         flags_q <= wData_q[7:0] & ssta_pkg::FLAG_MASK;
   end

   // Sticky completion flag, set wins over a write-one clear
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         done_q <= 1'b0;
      else if (state_q == ssta_pkg::ST_DONE)
         done_q <= 1'b1;
      else if (wrCommit && wStrb_q[0] && awAddr_q[7:2] == ssta_pkg::ADDR_STATUS[7:2] && wData_q[ssta_pkg::STAT_DONE])
         done_q <= 1'b0;
   end

   // ==========================================================
   // Operand address decode for the register file
   always_comb
   begin
      decodeWord = 32'h0000_0000;
      decodeWord[ssta_pkg::DEC_CYCLES +: 4] = opCycles(opcode_q);
      if (op == ssta_pkg::nibble_swap_op)
      begin
         decodeWord[ssta_pkg::DEC_DST_WORK]     = isWork(opnd_q[7:0]);
         decodeWord[ssta_pkg::DEC_DST_IDX +: 4] = opnd_q[3:0];
         decodeWord[ssta_pkg::DEC_DST_IND]      = opcode_q[0];
      end
      else if (op != ssta_pkg::no_op && form <= ssta_pkg::FORM_SHORT_LAST)
      begin
         decodeWord[ssta_pkg::DEC_DST_WORK]     = 1'b1;
         decodeWord[ssta_pkg::DEC_DST_IDX +: 4] = opnd_q[7:4];
         decodeWord[ssta_pkg::DEC_SRC_WORK]     = 1'b1;
         decodeWord[ssta_pkg::DEC_SRC_IDX +: 4] = opnd_q[3:0];
         decodeWord[ssta_pkg::DEC_SRC_IND]      = form == ssta_pkg::FORM_SHORT_LAST;
      end
      else if (op != ssta_pkg::no_op && form <= ssta_pkg::FORM_REG_IND)
      begin
         decodeWord[ssta_pkg::DEC_DST_WORK]     = isWork(opnd_q[15:8]);
         decodeWord[ssta_pkg::DEC_DST_IDX +: 4] = opnd_q[11:8];
         decodeWord[ssta_pkg::DEC_SRC_WORK]     = isWork(opnd_q[7:0]);
         decodeWord[ssta_pkg::DEC_SRC_IDX +: 4] = opnd_q[3:0];
         decodeWord[ssta_pkg::DEC_SRC_IND]      = form == ssta_pkg::FORM_REG_IND;
      end
      else if (op != ssta_pkg::no_op)
      begin
         decodeWord[ssta_pkg::DEC_DST_WORK]     = isWork(opnd_q[7:0]);
         decodeWord[ssta_pkg::DEC_DST_IDX +: 4] = opnd_q[3:0];
         decodeWord[ssta_pkg::DEC_DST_IND]      = form == ssta_pkg::FORM_IND_IMM;
         decodeWord[ssta_pkg::DEC_SRC_IMM]      = 1'b1;
      end
   end

   // ==========================================================
   // AXI4-Lite read channels
   always_comb
   begin
      rdNext = 32'h0000_0000;
      case (araddr[7:2])
         ssta_pkg::ADDR_CMD[7:2]:    rdNext[7:0] = opcode_q;
         ssta_pkg::ADDR_DST[7:2]:    rdNext[7:0] = dstVal_q;
         ssta_pkg::ADDR_SRC[7:2]:    rdNext[7:0] = srcVal_q;
         ssta_pkg::ADDR_FLAGS[7:2]:  rdNext[7:0] = flags_q;
         ssta_pkg::ADDR_OPND[7:2]:   rdNext[15:0] = opnd_q;
         ssta_pkg::ADDR_STATUS[7:2]:
         begin
            rdNext[ssta_pkg::STAT_BUSY]    = !idle;
            rdNext[ssta_pkg::STAT_DONE]    = done_q;
            rdNext[ssta_pkg::STAT_ILLEGAL] = illegal_q;
            rdNext[ssta_pkg::STAT_DSTWR]   = dstWr_q;
            rdNext[ssta_pkg::STAT_SRCWR]   = srcWr_q;
         end
         ssta_pkg::ADDR_RESULT[7:2]: rdNext[7:0] = result_q;
         ssta_pkg::ADDR_DECODE[7:2]: rdNext = decodeWord;
         default:                    rdNext = 32'h0000_0000;
      endcase
      if (!isMapped(araddr))
         rdNext = 32'h0000_0000;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= ssta_pkg::RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rdNext;
         rresp   <= isMapped(araddr) ? ssta_pkg::RESP_OKAY : ssta_pkg::RESP_SLVERR;
      end
      else if (rvalid && rready)
      begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ==========================================================
   // Checks
   logic [7:0] pDst_q;
   logic [7:0] pSrc_q;
   logic       pC_q;
   logic [7:0] pFlags_q;
   logic [3:0] busyLen_q;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pDst_q    <= 8'h00;
         pSrc_q    <= 8'h00;
         pC_q      <= 1'b0;
         pFlags_q  <= 8'h00;
         busyLen_q <= 4'h0;
      end
      else
      begin
         pDst_q    <= dstVal_q;
         pSrc_q    <= srcEff;
         pC_q      <= cIn;
         pFlags_q  <= flags_q;
         busyLen_q <= idle ? 4'h0 : busyLen_q + 4'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence doneSbc;
      state_q == ssta_pkg::ST_DONE && op == ssta_pkg::subtract_with_borrow_op;
   endsequence

   sequence doneTcm;
      state_q == ssta_pkg::ST_DONE && op == ssta_pkg::test_ones_under_mask_op;
   endsequence

   a_sbc_result_value:
   assert property (doneSbc |=> result_q == 8'(pDst_q - pSrc_q - {7'h00, pC_q}) && dstWr_q)
      else $error("Subtract result wrong");
   a_sbc_adder_form:
   assert property (op == ssta_pkg::subtract_with_borrow_op |-> sbcSum[7:0] == 8'(dstVal_q - srcEff - {7'h00, cIn}))
      else $error("Subtract adder disagrees");
   a_src_never_written:
   assert property (state_q == ssta_pkg::ST_DONE |=> !srcWr_q)
      else $error("Source marked as written");
   a_sbc_carry_borrow:
   assert property (doneSbc |=> flags_q[ssta_pkg::FLAG_C] == ({1'b0, pDst_q} < {1'b0, pSrc_q} + {8'h00, pC_q}))
      else $error("Borrow flag wrong");
   a_sbc_zero_flag:
   assert property (doneSbc |=> flags_q[ssta_pkg::FLAG_Z] == (result_q == 8'h00))
      else $error("Zero flag wrong after subtract");
   a_sbc_overflow_flag:
   assert property (doneSbc |=> flags_q[ssta_pkg::FLAG_V] == ((pDst_q[7] ^ pSrc_q[7]) & ~(result_q[7] ^ pSrc_q[7])))
      else $error("Overflow flag wrong after subtract");
   a_sbc_sign_flag:
   assert property (doneSbc |=> flags_q[ssta_pkg::FLAG_S] == result_q[7])
      else $error("Sign flag wrong after subtract");
   a_sbc_half_borrow:
   assert property (doneSbc |=> flags_q[ssta_pkg::FLAG_H] == ({1'b0, pDst_q[3:0]} < {1'b0, pSrc_q[3:0]} + {4'h0, pC_q}))
      else $error("Half borrow flag wrong");
   a_sbc_dadj_set:
   assert property (doneSbc |=> flags_q[ssta_pkg::FLAG_D])
      else $error("Decimal-adjust flag not set");
   a_exec_length:
   assert property (state_q == ssta_pkg::ST_DONE && op != ssta_pkg::no_op |-> busyLen_q + 4'h1 == opCycles(opcode_q))
      else $error("Execution length wrong");
   a_work_reg_select:
   assert property (op != ssta_pkg::no_op && form == ssta_pkg::FORM_IMM && isWork(opnd_q[7:0])
                    |-> decodeWord[ssta_pkg::DEC_DST_WORK] && decodeWord[ssta_pkg::DEC_DST_IDX +: 4] == opnd_q[3:0])
      else $error("Working register not selected");
   a_swap_result_flags:
   assert property (state_q == ssta_pkg::ST_DONE && op == ssta_pkg::nibble_swap_op
                    |=> result_q == {pDst_q[3:0], pDst_q[7:4]} && flags_q[ssta_pkg::FLAG_S] == result_q[7]
                        && (flags_q & 8'h8c) == (pFlags_q & 8'h8c))
      else $error("Swap result or flags wrong");
   a_tcm_zero_test:
   assert property (doneTcm |=> flags_q[ssta_pkg::FLAG_Z] == ((pDst_q | ~pSrc_q) == 8'hff))
      else $error("Mask test zero wrong");
   a_tcm_no_writeback:
   assert property (doneTcm |=> !dstWr_q && !srcWr_q)
      else $error("Mask test wrote an operand");
   a_tcm_other_flags:
   assert property (doneTcm |=> !flags_q[ssta_pkg::FLAG_V] && (flags_q & 8'h8c) == (pFlags_q & 8'h8c))
      else $error("Mask test flags wrong");

   c_sbc_borrow: cover property (doneSbc ##1 flags_q[ssta_pkg::FLAG_C]);
   c_swap_done:  cover property (state_q == ssta_pkg::ST_DONE && op == ssta_pkg::nibble_swap_op);
   c_tcm_zero:   cover property (doneTcm ##1 flags_q[ssta_pkg::FLAG_Z]);
   c_illegal:    cover property (state_q == ssta_pkg::ST_DONE && op == ssta_pkg::no_op);

endmodule : ssta_alu

// *** tb/testbench.sv ***
// Self-checking bench for the subtract, swap and mask-test unit
`timescale 1ns/1ps
module testbench;
   // ====================================
   // Bus signals and counters
   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hf;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, bSeen;
   logic [31:0] rdata;
   int          n_fail = 0, check_count = 0;

   always #5 clk = ~clk;

   ssta_alu i_dut (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

   // ====================================
   // Bus cycles and checks
   task automatic busW(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {awaddr, wdata} <= {a, d};
      {awvalid, wvalid, bready} <= 3'h7;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end
      while (!bvalid);
      bSeen = bresp;
      bready <= 1'h0;
   endtask : busW

   task automatic busR(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'h0;
      end
      while (!rvalid);
      {d, r} = {rdata, rresp};
      rready <= 1'h0;
   endtask : busR

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         n_fail++;
      end
   endtask : chk

   // Loads operands, executes, then checks write marks, result, flags and length
   task automatic run(input logic [7:0] op, dst, src, fl, input logic [15:0] opnd, input logic [7:0] eRes, eFl,
      input logic eWr);
      logic [31:0] d;
      logic [1:0]  r;
      busW(ssta_pkg::ADDR_DST, {24'h0, dst});
      busW(ssta_pkg::ADDR_SRC, {24'h0, src});
      busW(ssta_pkg::ADDR_FLAGS, {24'h0, fl});
      busW(ssta_pkg::ADDR_OPND, {16'h0, opnd});
      busW(ssta_pkg::ADDR_CMD, {24'h0, op});
      do
         busR(ssta_pkg::ADDR_STATUS, d, r);
      while (!d[ssta_pkg::STAT_DONE]);
      chk("writes", {29'h0, 1'h0, eWr, 1'h0}, {29'h0, d[4:2]});
      busR(ssta_pkg::ADDR_RESULT, d, r);
      chk("result", {24'h0, eRes}, d);
      busR(ssta_pkg::ADDR_FLAGS, d, r);
      chk("flags", {24'h0, eFl}, d);
      busR(ssta_pkg::ADDR_DECODE, d, r);
      chk("cycles", {28'h0, (op[3:0] < 4'h4) ? 4'h6 : 4'ha}, {28'h0, d[19:16]});
      busW(ssta_pkg::ADDR_STATUS, 32'h2);
   endtask : run

   // ====================================
   // Scenarios
   task automatic sbcCases;
      run(8'h32, 8'h16, 8'h20, 8'h80, 16'h003b, 8'hf5, 8'ha8, 1'h1);
      run(8'h33, 8'h10, 8'h0f, 8'h80, 16'h0000, 8'h00, 8'h4c, 1'h1);
   endtask : sbcCases

   task automatic formLoop;
      for (int f = 2; f < 8; f++)
      begin
         run({4'h3, 4'(f)}, 8'h80, 8'h01, 8'h00, 16'h01e3, 8'h7f, 8'h1c, 1'h1);
         run({4'h6, 4'(f)}, 8'h7f, 8'h80, 8'h00, 16'h80e3, 8'h80, 8'h20, 1'h0);
      end
   endtask : formLoop

   task automatic swapCases;
      run(8'hf0, 8'hb3, 8'h00, 8'h8c, 16'h00b3, 8'h3b, 8'h8c, 1'h1);
      run(8'hf1, 8'h00, 8'h00, 8'h10, 16'h00e5, 8'h00, 8'h50, 1'h1);
   endtask : swapCases

   task automatic maskZero;
      run(8'h62, 8'h45, 8'h01, 8'h9c, 16'h0037, 8'h00, 8'hcc, 1'h0);
   endtask : maskZero

   // Reset while idle returns flags and destination to their reset values
   task automatic resetCheck;
      logic [31:0] d;
      logic [1:0]  r;
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      busR(ssta_pkg::ADDR_FLAGS, d, r);
      chk("flags after reset", {24'h0, ssta_pkg::FLAGS_RESET}, d);
      busR(ssta_pkg::ADDR_DST, d, r);
      chk("dst after reset", 32'h0, d);
   endtask : resetCheck

   // Illegal opcode: illegal mark set, destination and flags kept
   task automatic illegalOp;
      logic [31:0] d;
      logic [1:0]  r;
      busW(ssta_pkg::ADDR_DST, 32'h5a);
      busW(ssta_pkg::ADDR_FLAGS, 32'h9c);
      busW(ssta_pkg::ADDR_CMD, 32'h31);
      do
         busR(ssta_pkg::ADDR_STATUS, d, r);
      while (!d[ssta_pkg::STAT_DONE]);
      chk("status", 32'h1, {29'h0, d[4:2]});
      busR(ssta_pkg::ADDR_RESULT, d, r);
      chk("result", 32'h5a, d);
      busR(ssta_pkg::ADDR_FLAGS, d, r);
      chk("flags", 32'h9c, d);
      busR(ssta_pkg::ADDR_DECODE, d, r);
      chk("cycles", {28'h0, ssta_pkg::CYC_ILLEGAL}, {28'h0, d[19:16]});
      busW(ssta_pkg::ADDR_STATUS, 32'h2);
   endtask : illegalOp

   // Operand write while busy is answered OKAY and ignored
   task automatic busyWrite;
      logic [31:0] d;
      logic [1:0]  r;
      busW(ssta_pkg::ADDR_DST, 32'h20);
      busW(ssta_pkg::ADDR_SRC, 32'h10);
      busW(ssta_pkg::ADDR_FLAGS, 32'h0);
      busW(ssta_pkg::ADDR_CMD, 32'h34);
      busW(ssta_pkg::ADDR_DST, 32'h77);
      chk("bresp busy", {30'h0, ssta_pkg::RESP_OKAY}, {30'h0, bSeen});
      do
         busR(ssta_pkg::ADDR_STATUS, d, r);
      while (!d[ssta_pkg::STAT_DONE]);
      busR(ssta_pkg::ADDR_DST, d, r);
      chk("dst kept", 32'h20, d);
      busR(ssta_pkg::ADDR_RESULT, d, r);
      chk("result", 32'h10, d);
      busW(ssta_pkg::ADDR_STATUS, 32'h2);
   endtask : busyWrite

   task automatic unmapped;
      logic [31:0] d;
      logic [1:0]  r;
      busR(8'h20, d, r);
      chk("rresp", {30'h0, ssta_pkg::RESP_SLVERR}, {30'h0, r});
      chk("rdata unmapped", 32'h0, d);
      busW(8'h24, 32'hff);
      chk("bresp", {30'h0, ssta_pkg::RESP_SLVERR}, {30'h0, bSeen});
   endtask : unmapped

   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      sbcCases();
      formLoop();
      swapCases();
      maskZero();
      resetCheck();
      illegalOp();
      busyWrite();
      unmapped();
      end_of_test();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
endmodule : testbench
